// ===== pkg/caw_map.svh
// Register map, field positions, timebase selections and divider counts
`ifndef CAW_MAP_SVH
`define CAW_MAP_SVH
// ****************************************
// Geometry
// ****************************************
`define CAW_NUM_MOD     5
`define CAW_DOG_MOD     4
`define CAW_ADDR_W      8
// ****************************************
// Register byte offsets
// ****************************************
`define CAW_OFF_FLAG    8'h00
`define CAW_OFF_AMODE   8'h04
`define CAW_OFF_CNT_LO  8'h08
`define CAW_OFF_CNT_HI  8'h0C
`define CAW_OFF_MODE0   8'h10
`define CAW_OFF_CMP0    8'h30
`define CAW_MODE_STEP   4
`define CAW_CMP_STEP    8
`define CAW_CMP_HI_OFF  4
// ****************************************
// Field positions
// ****************************************
`define CAW_FLG_OVF     7
`define CAW_FLG_RUN     6
`define CAW_AMR_IDLE    7
`define CAW_AMR_DOGEN   6
`define CAW_AMR_DOGLK   5
`define CAW_AMR_TSEL_HI 3
`define CAW_AMR_TSEL_LO 1
`define CAW_AMR_OVFIE   0
`define CAW_MD_WIDE     7
`define CAW_MD_CMPEN    6
`define CAW_MD_MATCH    3
`define CAW_MD_TOG      2
`define CAW_MD_PWM      1
`define CAW_MD_IRQEN    0
// ****************************************
// Timebase selections and divider counts
// ****************************************
`define CAW_TB_DIV12    3'h0
`define CAW_TB_DIV4     3'h1
`define CAW_TB_T0OVF    3'h2
`define CAW_TB_ECI      3'h3
`define CAW_TB_SYS      3'h4
`define CAW_TB_OSC8     3'h5
`define CAW_DIV12_LAST  4'hB
`define CAW_DIV4_LAST   4'h3
`define CAW_OSC8_LAST   3'h7
`endif

// ===== pkg/caw_pkg.sv
// State types for the counter array
`include "caw_map.svh"
package caw_pkg;
  // Main block state
  typedef struct packed {
    logic [15:0]                   cnt;
    logic [7:0]                    snap;
    logic                          run;
    logic                          ovf_flag;
    logic                          ovf_ie;
    logic                          idle_sus;
    logic                          dog_en;
    logic                          dog_lk;
    logic [2:0]                    tsel;
    logic [`CAW_NUM_MOD-1:0][7:0]  mode;
    logic [`CAW_NUM_MOD-1:0][7:0]  cmp_lo;
    logic [`CAW_NUM_MOD-1:0][7:0]  cmp_hi;
    logic [`CAW_NUM_MOD-1:0]       flags;
    logic [`CAW_NUM_MOD-1:0]       pins;
    logic                          irq;
    logic                          rst_pulse;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
  } caw_state_s;
  // Timebase state
  typedef struct packed {
    logic [3:0] div;
    logic [2:0] eci_s;
    logic [2:0] osc_s;
    logic [2:0] osc_cnt;
    logic       tick;
  } caw_tb_s;
endpackage

// ===== verification/caw_pin_load.sv
// Load model on the module output pins measuring level times and edges
`timescale 1ns/1ns
module caw_pin_load (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  pin_in,
  output logic      [15:0] gap_out    [5],
  output logic      [15:0] hi_len_out [5],
  output logic      [15:0] edges_out  [5]
);
  logic [4:0]  prev_q;
  logic [15:0] run_q [5];
  // Time each pin level and count its edges
  always_ff @(posedge sys_clk_in) begin
    prev_q <= pin_in;
    for (int i = 0; i < 5; i++) begin
      if (!rst_n_in) begin
        run_q[i]     <= 16'h0000;
        edges_out[i] <= 16'h0000;
      end else if (pin_in[i] != prev_q[i]) begin
        gap_out[i]   <= run_q[i];
        run_q[i]     <= 16'h0001;
        edges_out[i] <= edges_out[i] + 16'h0001;
        if (!pin_in[i]) hi_len_out[i] <= run_q[i];
      end else begin
        run_q[i] <= run_q[i] + 16'h0001;
      end
    end
  end
endmodule // caw_pin_load

// ===== verification/caw_top_sva.sv
// Port-level assertion checker for the counter array with watchdog
`timescale 1ns/1ns
`include "caw_map.svh"
module caw_top_sva (
  input wire logic                   sys_clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pwrite_in,
  input wire logic [`CAW_ADDR_W-1:0] paddr_in,
  input wire logic [31:0]            pwdata_in,
  input wire logic [31:0]            prdata_out,
  input wire logic                   pready_out,
  input wire logic                   pslverr_out,
  input wire logic                   irq_out,
  input wire logic                   sys_reset_out
);
  logic        dog_q;
  logic        lock_q;
  logic        wrote_q;
  logic        fired_q;
  logic [11:0] age_q;
  logic        wr_done;
  // Write completing at this edge
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
  // Shadow of watchdog state and age since reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dog_q   <= 1'b1;
      lock_q  <= 1'b0;
      wrote_q <= 1'b0;
      fired_q <= 1'b0;
      age_q   <= 12'h000;
    end else begin
      if (wr_done && paddr_in == `CAW_OFF_AMODE && !lock_q) begin
        dog_q  <= pwdata_in[`CAW_AMR_DOGEN] | pwdata_in[`CAW_AMR_DOGLK];
        lock_q <= pwdata_in[`CAW_AMR_DOGLK];
      end
      wrote_q <= wrote_q | (wr_done && paddr_in[7:3] != 5'h01);
      fired_q <= fired_q | sys_reset_out;
      age_q   <= (age_q == 12'hFFF) ? age_q : age_q + 12'h001;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held past one cycle");
  chk_ready_wait: assert property (psel_in && !penable_in |-> ##2 pready_out)
    else $error("access not answered after one wait state");
  chk_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_read_upper: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_reset_cause: assert property (sys_reset_out |-> $past(dog_q))
    else $error("system reset while watchdog off");
  chk_forced_reset: assert property (wr_done && paddr_in == `CAW_OFF_FLAG && pwdata_in[4]
    && dog_q |-> ##[1:2] sys_reset_out) else $error("flag write did not force reset");
  chk_flag_sticky: assert property ($fell(irq_out) |-> $past(wr_done))
    else $error("request dropped without software write");
  chk_dog_early: assert property (sys_reset_out && !wrote_q |-> age_q >= 12'd3060)
    else $error("default timeout too short");
  chk_dog_late: assert property (age_q == 12'd3100 && !wrote_q |-> fired_q)
    else $error("default timeout too long");
endmodule // caw_top_sva

// ===== verification/caw_top_test.sv
// Self-checking bench for the counter array with watchdog
`timescale 1ns/1ns
`include "caw_map.svh"
module caw_top_test;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready_out, pslverr_out;
  logic        irq_out, sys_reset_out, rerr;
  logic [7:0]  paddr, hb, db, tb;
  logic [31:0] pwdata, prdata_out, rdata;
  logic [4:0]  pins;
  logic [15:0] gap [5], hi_len [5], edges [5];
  logic [15:0] lfsr, e1;
  logic [7:0]  mode_tab [4] = '{8'h49, 8'h4C, 8'h46, 8'h42};
  int          mismatches, samples_checked, n, el;
  time         t0;
  caw_top dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cpu_idle_in(1'b0), .timer0_ovf_in(1'b0), .eci_in(1'b1), .ext_osc_in(1'b0),
    .module_output_pin_out(pins), .irq_out(irq_out), .sys_reset_out(sys_reset_out));
  caw_pin_load load (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .pin_in(pins),
    .gap_out(gap), .hi_len_out(hi_len), .edges_out(edges));
  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected half period of the frequency output, zero step meaning 256
  function automatic logic [31:0] exp_half(input logic [7:0] step);
    return (step == 8'h00) ? 32'd256 : 32'(step);
  endfunction
  // Expected high time of the narrow pulse output for a compare value
  function automatic logic [31:0] exp_high(input logic [7:0] c);
    return 32'd256 - 32'(c);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One register transfer, then one idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready_out !== 1'b1);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_dog(input int lim, output int c);
    c = 0;
    while (sys_reset_out !== 1'b1 && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  // Hang guard
  initial begin
    repeat (15000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    samples_checked = 0;
    lfsr = 16'h35BF;
    do_reset;
    t0 = $time;
    apb(`CAW_OFF_AMODE, 1'b0, 8'h00);
    check(rdata, 32'h40);
    apb(`CAW_OFF_FLAG, 1'b0, 8'h00);
    check(rdata, 32'h0);
    apb(`CAW_OFF_CNT_HI, 1'b1, 8'hAB);
    apb(`CAW_OFF_CNT_LO, 1'b0, 8'h00);
    apb(`CAW_OFF_CNT_HI, 1'b0, 8'h00);
    check(rdata, 32'h0);
    apb(8'hFC, 1'b0, 8'h00);
    check({31'h0, rerr}, 32'h1);
    check(rdata, 32'h0);
    wait_dog(3300, n);
    el = int'(($time - t0) / 10);
    check({31'h0, el > 3055 && el < 3100}, 32'h1);
    do_reset;
    apb(`CAW_OFF_AMODE, 1'b1, 8'h00);
    apb(`CAW_OFF_AMODE, 1'b1, 8'h08);
    apb(`CAW_OFF_AMODE, 1'b0, 8'h00);
    check(rdata, 32'h08);
    for (int p = 0; p < 2; p++) begin
      lfsr = next_rand(lfsr);
      tb = {2'b01, lfsr[5:0]};
      hb = (p == 1) ? 8'h00 : {4'h0, lfsr[9:6]} + 8'h02;
      db = (p == 1) ? 8'hFF : {lfsr[15:9], 1'b1};
      apb(`CAW_OFF_FLAG, 1'b1, 8'h00);
      apb(`CAW_OFF_CNT_LO, 1'b1, 8'h00);
      apb(`CAW_OFF_CNT_HI, 1'b1, 8'hFF);
      for (int m = 0; m < 4; m++) begin
        apb(`CAW_OFF_MODE0 + 8'(4 * m), 1'b1, mode_tab[m]);
        apb(`CAW_OFF_CMP0 + 8'(8 * m), 1'b1, m < 2 ? tb : (m == 2 ? 8'h00 : db));
        apb(`CAW_OFF_MODE0 + 8'(4 * m), 1'b0, 8'h00);
        check(rdata, {24'h0, mode_tab[m] & 8'hBF});
        apb(`CAW_OFF_CMP0 + 8'(8 * m + 4), 1'b1, m < 2 ? 8'hFF : (m == 2 ? hb : db));
      end
      apb(`CAW_OFF_MODE0, 1'b0, 8'h00);
      check(rdata, 32'h49);
      e1 = edges[1];
      apb(`CAW_OFF_FLAG, 1'b1, 8'h40);
      repeat (700) @(posedge sys_clk);
      // timer, toggle, frequency and narrow pulse
      check({31'h0, irq_out}, 32'h1);
      apb(`CAW_OFF_FLAG, 1'b0, 8'h00);
      check(rdata, 32'hC3);
      check(32'(edges[1] - e1), 32'h1);
      check(32'(gap[2]), exp_half(hb));
      check(32'(hi_len[3]), exp_high(db));
      apb(`CAW_OFF_FLAG, 1'b1, 8'h40);
      check({31'h0, irq_out}, 32'h0);
    end
    // wide pulse high from match to wrap
    apb(`CAW_OFF_FLAG, 1'b1, 8'h00);
    apb(`CAW_OFF_CNT_LO, 1'b1, 8'hE0);
    apb(`CAW_OFF_CNT_HI, 1'b1, 8'hFF);
    // match flag and interrupt enabled to pace updates
    apb(`CAW_OFF_MODE0 + 8'h0C, 1'b1, 8'hCB);
    apb(`CAW_OFF_CMP0 + 8'h18, 1'b1, 8'hF0);
    apb(`CAW_OFF_CMP0 + 8'h1C, 1'b1, 8'hFF);
    apb(`CAW_OFF_FLAG, 1'b1, 8'h40);
    repeat (100) @(posedge sys_clk);
    check(32'(hi_len[3]), 32'd16);
    check({31'h0, irq_out}, 32'h1);
    apb(`CAW_OFF_MODE0 + 8'h0C, 1'b1, 8'h42);
    apb(`CAW_OFF_CMP0 + 8'h18, 1'b1, 8'h00);
    apb(`CAW_OFF_CMP0 + 8'h1C, 1'b1, 8'h00);
    repeat (300) @(posedge sys_clk);
    e1 = edges[3];
    repeat (300) @(posedge sys_clk);
    check(32'(edges[3] - e1), 32'h0);
    check({31'h0, pins[3]}, 32'h1);
    apb(`CAW_OFF_CMP0 + 8'h18, 1'b1, 8'h00);
    repeat (300) @(posedge sys_clk);
    check({31'h0, pins[3]}, 32'h0);
    apb(`CAW_OFF_CMP0 + 8'h20, 1'b1, 8'h01);
    apb(`CAW_OFF_AMODE, 1'b1, 8'h48);
    // Run bit cleared, watchdog keeps the counter going
    apb(`CAW_OFF_FLAG, 1'b1, 8'h00);
    apb(`CAW_OFF_CMP0 + 8'h24, 1'b1, 8'h00);
    wait_dog(600, n);
    check({31'h0, n > 250 && n < 515}, 32'h1);
    do_reset;
    // lock holds and flag write forces reset
    apb(`CAW_OFF_AMODE, 1'b1, 8'h20);
    apb(`CAW_OFF_AMODE, 1'b1, 8'h88);
    apb(`CAW_OFF_AMODE, 1'b0, 8'h00);
    check(rdata, 32'h20);
    apb(`CAW_OFF_MODE0 + 8'h10, 1'b1, 8'h46);
    apb(`CAW_OFF_MODE0 + 8'h10, 1'b0, 8'h00);
    check(rdata, 32'h0);
    check({31'h0, pins[4]}, 32'h0);
    apb(`CAW_OFF_FLAG, 1'b1, 8'h10);
    wait_dog(4, n);
    check({31'h0, n < 3}, 32'h1);
    do_reset;
    close_out;
  end
endmodule // caw_top_test
bind caw_top caw_top_sva chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
  .sys_reset_out(sys_reset_out));

// ===== verilog/caw_timebase.sv
// Counter timebase: prescaler and synchronised external sources
`timescale 1ns/1ns
`include "caw_map.svh"
module caw_timebase
  import caw_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] tsel_in,
  input  wire logic       timer0_ovf_in,
  input  wire logic       eci_in,
  input  wire logic       ext_osc_in,
  output logic            tick_out
);
  caw_tb_s s_q;
  caw_tb_s s_d;
  logic [3:0] last;
  logic       eci_fall;
  logic       osc_rise;

  // Next state of prescaler and edge detectors
  always_comb begin
    s_d        = s_q;
    s_d.eci_s  = {s_q.eci_s[1:0], eci_in};
    s_d.osc_s  = {s_q.osc_s[1:0], ext_osc_in};
    eci_fall   = s_q.eci_s[2] & ~s_q.eci_s[1];
    osc_rise   = s_q.osc_s[1] & ~s_q.osc_s[2];
    last       = (tsel_in == `CAW_TB_DIV12) ? `CAW_DIV12_LAST : `CAW_DIV4_LAST;
    s_d.div    = (s_q.div >= last) ? 4'h0 : s_q.div + 4'h1;
    if (osc_rise) begin
      s_d.osc_cnt = s_q.osc_cnt + 3'h1;
    end
    case (tsel_in)
      `CAW_TB_DIV12,
      `CAW_TB_DIV4:  s_d.tick = (s_q.div == last);
      `CAW_TB_T0OVF: s_d.tick = timer0_ovf_in;
      `CAW_TB_ECI:   s_d.tick = eci_fall;
      `CAW_TB_SYS:   s_d.tick = 1'b1;
      `CAW_TB_OSC8:  s_d.tick = osc_rise & (s_q.osc_cnt == `CAW_OSC8_LAST);
      default:       s_d.tick = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
endmodule // caw_timebase

// ===== verilog/caw_top.sv
// Counter array compare modules and module 4 watchdog with APB registers
`timescale 1ns/1ns
`include "caw_map.svh"
module caw_top
  import caw_pkg::*;
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [`CAW_ADDR_W-1:0]   paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic                     cpu_idle_in,
  input  wire logic                     timer0_ovf_in,
  input  wire logic                     eci_in,
  input  wire logic                     ext_osc_in,
  output logic      [`CAW_NUM_MOD-1:0]  module_output_pin_out,
  output logic                          irq_out,
  output logic                          sys_reset_out
);
  caw_state_s s_q;
  caw_state_s s_d;
  logic       tick;
  logic       dog_on;
  logic       cnt_step;
  logic [15:0] cnt_nx;
  logic       lo_ovf;
  logic       hi_ovf;
  logic       acc_first;
  logic       wr_do;
  logic       rd_do;
  logic       hit;
  logic [7:0] rd_val;
  logic [7:0] wb;
  logic [7:0] md;
  logic [7:0] eff;
  logic       active;
  logic       is_dog;
  logic       freq_m;
  logic       pwm8_m;
  logic       pwm16_m;
  logic       m16;
  logic       m8;

  // ****************************************
  // Counter timebase
  // ****************************************
  caw_timebase u_tb (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .tsel_in       (s_q.tsel),
    .timer0_ovf_in (timer0_ovf_in),
    .eci_in        (eci_in),
    .ext_osc_in    (ext_osc_in),
    .tick_out      (tick)
  );

  // ****************************************
  // Next state logic
  // ****************************************
  always_comb begin
    s_d           = s_q;
    s_d.rst_pulse = 1'b0;
    wb            = pwdata_in[7:0];
    rd_val        = 8'h00;
    hit           = 1'b0;
    eff           = 8'h00;
    md            = 8'h00;
    active        = 1'b0;
    is_dog        = 1'b0;
    freq_m        = 1'b0;
    pwm8_m        = 1'b0;
    pwm16_m       = 1'b0;
    m16           = 1'b0;
    m8            = 1'b0;
    dog_on        = s_q.dog_en | s_q.dog_lk;
    cnt_step      = tick & (s_q.run | dog_on) & ~(s_q.idle_sus & cpu_idle_in);
    cnt_nx        = s_q.cnt + 16'h0001;
    lo_ovf        = cnt_step & (s_q.cnt[7:0] == 8'hFF);
    hi_ovf        = cnt_step & (s_q.cnt == 16'hFFFF);
    acc_first     = psel_in & penable_in & ~s_q.pready;
    wr_do         = psel_in & penable_in & s_q.pready & pwrite_in;
    rd_do         = psel_in & penable_in & s_q.pready & ~pwrite_in;

    // Read decode for fixed registers
    case (paddr_in)
      `CAW_OFF_FLAG: begin
        hit    = 1'b1;
        rd_val = {s_q.ovf_flag, s_q.run, 1'b0, s_q.flags};
      end
      `CAW_OFF_AMODE: begin
        hit    = 1'b1;
        rd_val = {s_q.idle_sus, s_q.dog_en, s_q.dog_lk, 1'b0, s_q.tsel, s_q.ovf_ie};
      end
      `CAW_OFF_CNT_LO: begin
        hit    = 1'b1;
        rd_val = s_q.cnt[7:0];
      end
      `CAW_OFF_CNT_HI: begin
        hit    = 1'b1;
        rd_val = s_q.snap;
      end
      default: begin
        hit    = 1'b0;
      end
    endcase
    // Read decode for per-module registers
    for (int i = 0; i < `CAW_NUM_MOD; i++) begin
      if (paddr_in == 8'(`CAW_OFF_MODE0 + `CAW_MODE_STEP * i)) begin
        hit    = 1'b1;
        rd_val = s_q.mode[i];
      end
      if (paddr_in == 8'(`CAW_OFF_CMP0 + `CAW_CMP_STEP * i)) begin
        hit    = 1'b1;
        rd_val = s_q.cmp_lo[i];
      end
      if (paddr_in == 8'(`CAW_OFF_CMP0 + `CAW_CMP_STEP * i + `CAW_CMP_HI_OFF)) begin
        hit    = 1'b1;
        rd_val = s_q.cmp_hi[i];
      end
    end

    // APB answer: ready one cycle into the access phase
    s_d.pready  = acc_first;
    s_d.pslverr = acc_first & ~hit;
    s_d.prdata  = (acc_first & ~pwrite_in & hit) ? {24'h000000, rd_val} : 32'h00000000;

    // Low byte read latches the high byte, one cycle after the low byte was sampled
    if (rd_do && paddr_in == `CAW_OFF_CNT_LO) begin
      s_d.snap = s_q.cnt[15:8];
    end

    // Counter advance
    if (cnt_step) begin
      s_d.cnt = cnt_nx;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (wr_do) begin
      case (paddr_in)
        `CAW_OFF_FLAG: begin
          s_d.flags    = s_q.flags & wb[`CAW_NUM_MOD-1:0];
          s_d.ovf_flag = s_q.ovf_flag & wb[`CAW_FLG_OVF];
          s_d.run      = wb[`CAW_FLG_RUN];
          if (dog_on && wb[`CAW_DOG_MOD]) begin
            s_d.rst_pulse = 1'b1;
          end
        end
        `CAW_OFF_AMODE: begin
          s_d.dog_lk = s_q.dog_lk | wb[`CAW_AMR_DOGLK];
          if (!s_q.dog_lk) begin
            s_d.dog_en = wb[`CAW_AMR_DOGEN];
          end
          if (!dog_on) begin
            s_d.idle_sus = wb[`CAW_AMR_IDLE];
            s_d.tsel     = wb[`CAW_AMR_TSEL_HI:`CAW_AMR_TSEL_LO];
            s_d.ovf_ie   = wb[`CAW_AMR_OVFIE];
          end
        end
        `CAW_OFF_CNT_LO: begin
          if (!dog_on) begin
            s_d.cnt[7:0] = wb;
          end
        end
        `CAW_OFF_CNT_HI: begin
          if (!dog_on) begin
            s_d.cnt[15:8] = wb;
          end
        end
        default: begin
          s_d.run = s_q.run;
        end
      endcase
      for (int i = 0; i < `CAW_NUM_MOD; i++) begin
        is_dog = dog_on && (i == `CAW_DOG_MOD);
        if (paddr_in == 8'(`CAW_OFF_MODE0 + `CAW_MODE_STEP * i) && !is_dog) begin
          s_d.mode[i] = wb;
        end
        if (paddr_in == 8'(`CAW_OFF_CMP0 + `CAW_CMP_STEP * i)) begin
          s_d.cmp_lo[i]            = wb;
          s_d.mode[i][`CAW_MD_CMPEN] = 1'b0;
        end
        if (paddr_in == 8'(`CAW_OFF_CMP0 + `CAW_CMP_STEP * i + `CAW_CMP_HI_OFF)) begin
          s_d.mode[i][`CAW_MD_CMPEN] = 1'b1;
          if (is_dog) begin
            s_d.cmp_hi[i] = s_q.cnt[15:8] + s_q.cmp_lo[i];
          end else begin
            s_d.cmp_hi[i] = wb;
          end
        end
      end
    end

    // ****************************************
    // Compare modules
    // ****************************************
    for (int i = 0; i < `CAW_NUM_MOD; i++) begin
      is_dog  = dog_on && (i == `CAW_DOG_MOD);
      md      = s_q.mode[i];
      active  = md[`CAW_MD_CMPEN] & ~is_dog;
      freq_m  = md[`CAW_MD_PWM] & md[`CAW_MD_TOG];
      pwm8_m  = md[`CAW_MD_PWM] & ~md[`CAW_MD_TOG] & ~md[`CAW_MD_WIDE];
      pwm16_m = md[`CAW_MD_PWM] & ~md[`CAW_MD_TOG] & md[`CAW_MD_WIDE];
      m16     = cnt_step & (cnt_nx == {s_q.cmp_hi[i], s_q.cmp_lo[i]});
      m8      = cnt_step & (cnt_nx[7:0] == s_q.cmp_lo[i]);
      if (active) begin
        if (freq_m) begin
          if (m8) begin
            s_d.pins[i]   = ~s_q.pins[i];
            // zero step wraps a full 256
            s_d.cmp_lo[i] = s_q.cmp_lo[i] + s_q.cmp_hi[i];
            if (md[`CAW_MD_MATCH]) begin
              s_d.flags[i] = 1'b1;
            end
          end
        end else if (pwm8_m) begin
          eff = lo_ovf ? s_q.cmp_hi[i] : s_q.cmp_lo[i];
          if (lo_ovf) begin
            s_d.cmp_lo[i] = s_q.cmp_hi[i];
            s_d.pins[i]   = 1'b0;
          end
          // set beats clear, zero gives full duty
          if (cnt_step && cnt_nx[7:0] == eff) begin
            s_d.pins[i] = 1'b1;
            if (md[`CAW_MD_MATCH]) begin
              s_d.flags[i] = 1'b1;
            end
          end
        end else if (pwm16_m) begin
          // clear on overflow, set on match
          if (hi_ovf) begin
            s_d.pins[i] = 1'b0;
          end
          if (m16) begin
            s_d.pins[i] = 1'b1;
            if (md[`CAW_MD_MATCH]) begin
              s_d.flags[i] = 1'b1;
            end
          end
        end else if (md[`CAW_MD_MATCH] && m16) begin
          s_d.flags[i] = 1'b1;
          if (md[`CAW_MD_TOG]) begin
            s_d.pins[i] = ~s_q.pins[i];
          end
        end
      end else if (md[`CAW_MD_PWM] && !is_dog) begin
        s_d.pins[i] = 1'b0;
      end
    end

    // Overflow flag, set wins over clear
    if (hi_ovf) begin
      s_d.ovf_flag = 1'b1;
    end

    if (dog_on && lo_ovf && s_q.cmp_hi[`CAW_DOG_MOD] == s_q.cnt[15:8]) begin
      s_d.rst_pulse = 1'b1;
    end

    s_d.irq = 1'b0;
    for (int i = 0; i < `CAW_NUM_MOD; i++) begin
      if (s_d.flags[i] && s_d.mode[i][`CAW_MD_IRQEN]) begin
        s_d.irq = 1'b1;
      end
    end
    if (s_d.ovf_flag && s_d.ovf_ie) begin
      s_d.irq = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q        <= '0;
      s_q.dog_en <= 1'b1;
      s_q.tsel   <= `CAW_TB_DIV12;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata_out            = s_q.prdata;
  assign pready_out            = s_q.pready;
  assign pslverr_out           = s_q.pslverr;
  assign module_output_pin_out = s_q.pins;
  assign irq_out               = s_q.irq;
  assign sys_reset_out         = s_q.rst_pulse;
endmodule // caw_top
